// file: src/ccr_delay_timer.sv
// counts a programmable number of cycles while its start level holds
`timescale 1ns/1ns
`default_nettype none
module ccr_delay_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             i_sys_clk, // system clock
  input  wire logic             i_srst,    // sync reset, high
  input  wire logic             i_run,     // count while high
  input  wire logic [WIDTH-1:0] i_limit,   // cycles to wait
  output logic                  o_done     // high once limit reached
);
  // refused at elaboration: the counter and its compare need 2 to 32 bits
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("ccr_delay_timer width out of range");
  end
  logic [WIDTH-1:0] cnt_reg;
  wire              at_limit = (cnt_reg >= i_limit);
  // counter restarts whenever the start level drops
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_run) begin
      cnt_reg <= '0;
    end else if (!at_limit) begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  assign o_done = i_run && at_limit;
endmodule
`default_nettype wire

// file: src/ccr_glitch_filter.sv
// high-level deglitch of the enable pin with a programmable time
`timescale 1ns/1ns
`default_nettype none
module ccr_glitch_filter #(
  parameter int WIDTH = 24
) (
  input  wire logic             i_sys_clk, // system clock
  input  wire logic             i_srst,    // sync reset, high
  input  wire logic             i_pin,     // raw enable pin level
  input  wire logic [WIDTH-1:0] i_limit,   // required high cycles
  output logic                  o_level    // filtered level
);
  // refused at elaboration: the counter and its compare need 2 to 32 bits
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("ccr_glitch_filter width out of range");
  end
  logic [WIDTH-1:0] cnt_reg;
  logic             level_reg;
  // only the rising side is filtered; a low pin drops the level at once
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_pin) begin
      cnt_reg   <= '0;
      level_reg <= 1'b0;
    end else if (cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1} >= i_limit) begin
      level_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  assign o_level = level_reg;
endmodule
`default_nettype wire

// file: src/ccr_pkg.sv
// constants shared by the converter control register bank
// *****************************************************************
// *****************************************************************
package ccr_pkg;
  // *****************************************************************
  // register map
  // *****************************************************************
  localparam logic [7:0] ADDR_ENABLE_CONFIG = 8'h05;
  localparam logic [7:0] ADDR_CONV_CFG_A    = 8'h06;
  localparam logic [7:0] ADDR_CONV_CFG_B    = 8'h07;
  localparam logic [7:0] ADDR_HR_OV_CFG     = 8'h08;
  localparam logic [7:0] RST_ENABLE_CONFIG  = 8'h80;
  localparam logic [7:0] RST_CONV_CFG_A     = 8'h16;
  localparam logic [7:0] RST_CONV_CFG_B     = 8'h32;
  localparam logic [7:0] RST_HR_OV_CFG      = 8'hb0;
  // writable bit masks; reserved bits stay zero
  localparam logic [7:0] WMASK_ENABLE_CONFIG = 8'hff;
  localparam logic [7:0] WMASK_CONV_CFG_A    = 8'hff;
  localparam logic [7:0] WMASK_CONV_CFG_B    = 8'hbf;
  localparam logic [7:0] WMASK_HR_OV_CFG     = 8'hfb;
  // field positions
  localparam int BIT_PULLDOWN    = 7;
  localparam int BIT_REG_RESET   = 6;
  localparam int BIT_HARD_RST_EN = 5;
  localparam int BIT_SHIP_EN     = 4;
  localparam int POS_GLITCH      = 1;
  localparam int BIT_RUN         = 0;
  localparam int BIT_POK_WAIT    = 7;
  localparam int BIT_SHIP_KEY    = 6;
  localparam int POS_DRAIN_T     = 4;
  localparam int BIT_AUDIO_SKIP  = 3;
  localparam int BIT_HR_DRAIN    = 2;
  localparam int BIT_LR_DRAIN    = 1;
  localparam int BIT_CONST_RATE  = 0;
  localparam int BIT_OC_OFF      = 7;
  localparam int POS_SPREAD      = 4;
  localparam int BIT_PHASE       = 3;
  localparam int POS_RATE        = 0;
  localparam int POS_OV_LEVEL    = 3;
  localparam int POS_EXIT_LEVEL  = 0;
  // *****************************************************************
  // timing
  // *****************************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int SHIP_SHORT_S    = 20;
  localparam int SHIP_LONG_S     = 30;
  localparam int POK_WAIT_MS     = 100;
  localparam int GLITCH_BASE_US  = 125;
  localparam int SHIP_SHORT_CYC  = SHIP_SHORT_S * CLK_HZ;
  localparam int SHIP_LONG_CYC   = SHIP_LONG_S * CLK_HZ;
  localparam int POK_WAIT_CYC    = POK_WAIT_MS * (CLK_HZ / 1000);
  localparam int GLITCH_BASE_CYC = GLITCH_BASE_US * (CLK_HZ / 1_000_000);
  localparam int MS_CYC          = CLK_HZ / 1000;
endpackage

// file: src/ccr_regs.sv
// converter control register bank with ship, power ok and enable logic
`timescale 1ns/1ns
`default_nettype none
module ccr_regs #(
  parameter int SHIP_SHORT_CYC = ccr_pkg::SHIP_SHORT_CYC, // 20 s delay
  parameter int SHIP_LONG_CYC  = ccr_pkg::SHIP_LONG_CYC,  // 30 s delay
  parameter int POK_WAIT_CYC   = ccr_pkg::POK_WAIT_CYC,   // 100 ms wait
  parameter int MS_CYC         = ccr_pkg::MS_CYC          // cycles per ms
) (
  input  wire logic       i_sys_clk,          // 20 MHz clock
  input  wire logic       i_srst,             // sync reset, high
  input  wire logic [7:0] i_reg_addr,         // register address from i2c port
  input  wire logic [7:0] i_reg_wdata,        // write data
  input  wire logic       i_reg_wr,           // write strobe, one cycle
  input  wire logic       i_reg_rd,           // read strobe, one cycle
  output logic [7:0]      o_reg_rdata,        // read data, registered
  output logic            o_reg_ack,          // read data valid pulse
  input  wire logic       i_sys_reset_done,   // end of system reset period
  input  wire logic       i_ship_long_sel,    // 1 selects 30 s ship delay
  input  wire logic       i_ship_exit,        // device leaves ship mode
  input  wire logic       i_charge_fault,     // drive supply or cap fault
  input  wire logic       i_low_rail_ss_ok,   // low rail soft start done
  input  wire logic       i_enable_pin,       // raw enable pin
  output logic            o_enable_pin_level, // deglitched enable pin
  output logic            o_enter_ship,       // ship mode request level
  output logic            o_power_ok_output,  // power ok level
  output logic            o_enable_pin_pulldown_on, // pull-down control
  output logic            o_converter_run,    // converter enable
  output logic [1:0]      o_gentle_drain_time, // soft discharge code
  output logic            o_above_hearing_skip_on, // out of audio skip
  output logic            o_high_rail_drain_on, // high rail discharge
  output logic            o_low_rail_drain_on,  // low rail discharge
  output logic            o_constant_rate_on,   // fixed frequency
  output logic            o_low_rail_overcurrent_off, // oc protection off
  output logic [1:0]      o_spread_spectrum_sel, // dithering code
  output logic            o_channel_phase_sel,   // 0=180 deg 1=90 deg
  output logic [2:0]      o_switching_rate_sel,  // frequency code
  output logic [4:0]      o_high_rail_overvoltage_level, // ov threshold code
  output logic [1:0]      o_high_rail_exit_level  // exit threshold code
);
  // code 7 shifts MS_CYC left by six, and the result must still fit 24 bits
  if (SHIP_SHORT_CYC < 1 || SHIP_LONG_CYC < 1 || POK_WAIT_CYC < 1 ||
      MS_CYC < 1 || MS_CYC > 262143) begin : g_bad_timing
    $error("ccr_regs timing parameter out of range");
  end
  // *****************************************************************
  // register storage
  // *****************************************************************
  logic [7:0] en_cfg_reg;
  logic [7:0] en_cfg_next;
  logic [7:0] cfg_a_reg;
  logic [7:0] cfg_a_next;
  logic [7:0] cfg_b_reg;
  logic [7:0] cfg_b_next;
  logic [7:0] ov_reg;
  logic [7:0] ov_next;
  logic [7:0] rdata_reg;
  logic       ack_reg;
  logic       reg_reset_pend_reg;
  logic       hard_rst_pend_reg;

  // address decode
  wire sel_en  = (i_reg_addr == ccr_pkg::ADDR_ENABLE_CONFIG);
  wire sel_a   = (i_reg_addr == ccr_pkg::ADDR_CONV_CFG_A);
  wire sel_b   = (i_reg_addr == ccr_pkg::ADDR_CONV_CFG_B);
  wire sel_ov  = (i_reg_addr == ccr_pkg::ADDR_HR_OV_CFG);
  wire wr_en   = i_reg_wr && sel_en;
  wire wr_a    = i_reg_wr && sel_a;
  wire wr_b    = i_reg_wr && sel_b;
  wire wr_ov   = i_reg_wr && sel_ov;

  // a pending register reset or hard reset restores every default;
  // the reset bit is held one cycle so software can see it was taken
  wire hard_rst_fire = en_cfg_reg[ccr_pkg::BIT_HARD_RST_EN] && i_sys_reset_done;
  wire defaults_load = reg_reset_pend_reg || hard_rst_pend_reg;

  // *****************************************************************
  // status driven clears
  // *****************************************************************
  wire ship_exit_clr = i_ship_exit;
  wire fault_clr     = i_charge_fault;

  // enable config next value: writes first, hardware clears override
  always_comb begin
    en_cfg_next = en_cfg_reg;
    if (wr_en) begin
      en_cfg_next = i_reg_wdata & ccr_pkg::WMASK_ENABLE_CONFIG;
    end
    if (ship_exit_clr) begin
      en_cfg_next[ccr_pkg::BIT_SHIP_EN] = 1'b0;
    end
    if (fault_clr) begin
      en_cfg_next[ccr_pkg::BIT_RUN] = 1'b0;
    end
  end

  // reserved bits are masked off on every write
  always_comb begin
    cfg_a_next = wr_a  ? (i_reg_wdata & ccr_pkg::WMASK_CONV_CFG_A) : cfg_a_reg;
    cfg_b_next = wr_b  ? (i_reg_wdata & ccr_pkg::WMASK_CONV_CFG_B) : cfg_b_reg;
    ov_next    = wr_ov ? (i_reg_wdata & ccr_pkg::WMASK_HR_OV_CFG)  : ov_reg;
  end

  // register update, defaults on reset or on the software reset action
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || defaults_load) begin
      en_cfg_reg <= ccr_pkg::RST_ENABLE_CONFIG;
      cfg_a_reg  <= ccr_pkg::RST_CONV_CFG_A;
      cfg_b_reg  <= ccr_pkg::RST_CONV_CFG_B;
      ov_reg     <= ccr_pkg::RST_HR_OV_CFG;
    end else begin
      en_cfg_reg <= en_cfg_next;
      cfg_a_reg  <= cfg_a_next;
      cfg_b_reg  <= cfg_b_next;
      ov_reg     <= ov_next;
    end
  end

  // reset requests are taken one cycle after they appear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      reg_reset_pend_reg <= 1'b0;
      hard_rst_pend_reg  <= 1'b0;
    end else begin
      reg_reset_pend_reg <= en_cfg_next[ccr_pkg::BIT_REG_RESET] && !defaults_load;
      hard_rst_pend_reg  <= hard_rst_fire && !defaults_load;
    end
  end

  // *****************************************************************
  // read port
  // *****************************************************************
  wire [7:0] rd_mux = sel_en ? en_cfg_reg :
                      sel_a  ? cfg_a_reg  :
                      sel_b  ? cfg_b_reg  :
                      sel_ov ? ov_reg     : 8'h00; // unmapped reads zero

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rdata_reg <= 8'h00;
      ack_reg   <= 1'b0;
    end else begin
      ack_reg <= i_reg_rd;
      if (i_reg_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end
  assign o_reg_rdata = rdata_reg;
  assign o_reg_ack   = ack_reg;

  // *****************************************************************
  // ship mode entry timer
  // *****************************************************************
  // both keys must stay set for the whole delay; dropping either restarts it
  wire        ship_armed = en_cfg_reg[ccr_pkg::BIT_SHIP_EN] &&
                           cfg_a_reg[ccr_pkg::BIT_SHIP_KEY];
  wire [31:0] ship_limit = i_ship_long_sel ? 32'(SHIP_LONG_CYC) :
                                             32'(SHIP_SHORT_CYC);
  ccr_delay_timer #(.WIDTH(32)) u_ship_timer (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_run     (ship_armed),
    .i_limit   (ship_limit),
    .o_done    (o_enter_ship)
  );

  // *****************************************************************
  // power ok delay
  // *****************************************************************
  wire        pok_nowait = cfg_a_reg[ccr_pkg::BIT_POK_WAIT];
  wire        pok_timed;
  ccr_delay_timer #(.WIDTH(32)) u_pok_timer (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_run     (i_low_rail_ss_ok),
    .i_limit   (32'(POK_WAIT_CYC)),
    .o_done    (pok_timed)
  );
  assign o_power_ok_output = i_low_rail_ss_ok && (pok_nowait || pok_timed);

  // *****************************************************************
  // enable pin deglitch
  // *****************************************************************
  // code 0 is 0.125 ms, code n is 2^(n-1) ms; up to 64 ms fits 24 bits
  wire [2:0]  glitch_code = en_cfg_reg[ccr_pkg::POS_GLITCH +: 3];
  wire [2:0]  glitch_sh   = glitch_code - 3'h1;
  wire [23:0] glitch_ms   = 24'(MS_CYC) << glitch_sh;
  wire [23:0] glitch_lim  = (glitch_code == 3'h0) ? 24'(ccr_pkg::GLITCH_BASE_CYC) :
                                                    glitch_ms;
  ccr_glitch_filter #(.WIDTH(24)) u_en_filter (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_pin     (i_enable_pin),
    .i_limit   (glitch_lim),
    .o_level   (o_enable_pin_level)
  );

  // *****************************************************************
  // configuration outputs to the analog side
  // *****************************************************************
  assign o_enable_pin_pulldown_on      = en_cfg_reg[ccr_pkg::BIT_PULLDOWN];
  assign o_converter_run               = en_cfg_reg[ccr_pkg::BIT_RUN];
  assign o_gentle_drain_time           = cfg_a_reg[ccr_pkg::POS_DRAIN_T +: 2];
  assign o_above_hearing_skip_on       = cfg_a_reg[ccr_pkg::BIT_AUDIO_SKIP];
  assign o_high_rail_drain_on          = cfg_a_reg[ccr_pkg::BIT_HR_DRAIN];
  assign o_low_rail_drain_on           = cfg_a_reg[ccr_pkg::BIT_LR_DRAIN];
  assign o_constant_rate_on            = cfg_a_reg[ccr_pkg::BIT_CONST_RATE];
  assign o_low_rail_overcurrent_off    = cfg_b_reg[ccr_pkg::BIT_OC_OFF];
  assign o_spread_spectrum_sel         = cfg_b_reg[ccr_pkg::POS_SPREAD +: 2];
  assign o_channel_phase_sel           = cfg_b_reg[ccr_pkg::BIT_PHASE];
  assign o_switching_rate_sel          = cfg_b_reg[ccr_pkg::POS_RATE +: 3];
  assign o_high_rail_overvoltage_level = ov_reg[ccr_pkg::POS_OV_LEVEL +: 5];
  assign o_high_rail_exit_level        = ov_reg[ccr_pkg::POS_EXIT_LEVEL +: 2];
endmodule
`default_nettype wire

// file: testbench/ccr_host_model.sv
// host model driving the register strobes of the bank
`timescale 1ns/1ns
`default_nettype none
module ccr_host_model (
  input  wire logic       i_sys_clk,   // system clock
  input  wire logic [7:0] i_reg_rdata, // read data
  input  wire logic       i_reg_ack,   // read valid
  output var  logic [7:0] o_reg_addr,  // address
  output var  logic [7:0] o_reg_wdata, // write data
  output var  logic       o_reg_wr,    // write strobe
  output var  logic       o_reg_rd     // read strobe
);
  // idle bus; reserved bits are written as zero unless a caller tests refusal
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
  end
  // one-cycle strobe between falling edges; next call waits a full edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(negedge i_sys_clk);
    o_reg_wr    = 1'b0;
  endtask
  // ack stands in the cycle after the read edge, so it is sampled there
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge i_sys_clk);
    o_reg_addr = a;
    o_reg_rd   = 1'b1;
    @(negedge i_sys_clk);
    o_reg_rd   = 1'b0;
    ok         = (i_reg_ack === 1'b1);
    d          = i_reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: testbench/ccr_regs_chk.sv
// assertion checker on the ports of the converter control register bank
`timescale 1ns/1ns
`default_nettype none
module ccr_regs_chk #(
  parameter int MS_CYC = 20 // cycles per ms, glitch filter time of code 1
) (
  input wire logic       i_sys_clk,               // clock
  input wire logic       i_srst,                  // sync reset
  input wire logic [7:0] i_reg_addr,              // address
  input wire logic [7:0] i_reg_wdata,             // write data
  input wire logic       i_reg_wr,                // write strobe
  input wire logic       i_reg_rd,                // read strobe
  input wire logic       o_reg_ack,               // read valid
  input wire logic       i_sys_reset_done,        // end of system reset
  input wire logic       i_ship_exit,             // ship mode left
  input wire logic       i_charge_fault,          // charging fault
  input wire logic       i_low_rail_ss_ok,        // soft start done
  input wire logic       i_enable_pin,            // raw pin
  input wire logic       o_enable_pin_level,      // filtered pin
  input wire logic       o_enter_ship,            // ship request
  input wire logic       o_power_ok_output,       // power ok
  input wire logic       o_enable_pin_pulldown_on, // pull-down
  input wire logic       o_converter_run,         // converter enable
  input wire logic       o_low_rail_overcurrent_off, // oc off
  input wire logic [1:0] o_spread_spectrum_sel,   // dithering
  input wire logic       o_channel_phase_sel,     // phase
  input wire logic [2:0] o_switching_rate_sel     // rate
);
  // *****************************************************************
  // helpers
  // *****************************************************************
  logic        trig_reg; // a defaults load may swallow this cycle's write
  logic [15:0] hi_cnt_reg; // consecutive high samples of the pin
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      trig_reg   <= 1'b0;
      hi_cnt_reg <= 16'h0000;
    end else begin
      trig_reg   <= i_sys_reset_done | (i_reg_wr & (i_reg_addr == 8'h05) & i_reg_wdata[6]);
      hi_cnt_reg <= !i_enable_pin ? 16'h0000 : hi_cnt_reg + {15'h0000, hi_cnt_reg != 16'hffff};
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // *****************************************************************
  // assertions
  // *****************************************************************
  ack_after_read_a: assert property (i_reg_rd |=> o_reg_ack)
    else $error("read not answered");
  ack_has_cause_a: assert property (o_reg_ack |-> $past(i_reg_rd))
    else $error("ack without read");
  fault_clears_run_a: assert property (i_charge_fault |=> !o_converter_run)
    else $error("run kept after fault");
  run_needs_write_a: assert property ($rose(o_converter_run) |->
    $past(i_reg_wr && i_reg_addr == 8'h05 && i_reg_wdata[0])) else $error("run rose alone");
  pok_needs_ss_a: assert property (!i_low_rail_ss_ok |-> !o_power_ok_output)
    else $error("power ok without soft start");
  pin_low_drop_a: assert property (!i_enable_pin |=> !o_enable_pin_level)
    else $error("filtered pin kept high");
  glitch_min_a: assert property (
    $rose(o_enable_pin_level) |-> hi_cnt_reg >= MS_CYC - 1)
    else $error("pin passed too soon");
  cfg_b_write_a: assert property (
    i_reg_wr && i_reg_addr == 8'h07 && !trig_reg |=>
    {o_low_rail_overcurrent_off, o_spread_spectrum_sel, o_channel_phase_sel,
     o_switching_rate_sel} == {$past(i_reg_wdata[7]), $past(i_reg_wdata[5:0])})
    else $error("config b outputs wrong");
  exit_stops_ship_a: assert property (i_ship_exit |-> ##[1:2] !o_enter_ship)
    else $error("ship request kept");
  reset_defaults_a: assert property (
    $fell(i_srst) |-> o_enable_pin_pulldown_on &&
    !o_converter_run && o_switching_rate_sel == 3'h2 && o_spread_spectrum_sel == 2'h3)
    else $error("reset defaults wrong");
endmodule
`default_nettype wire

// file: testbench/ccr_regs_tb_top.sv
// self-checking testbench of the converter control register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h seen %0h", n, e, g); end end
module ccr_regs_tb_top;
  logic clk, srst, wr, rd, ack, done, lsel, sexit, fault, ss_ok, pin, lvl, ship, pok, pd, run;
  logic skip, hrd, lrd, crate, oc, phase;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] drain_t, spread, exit_lv;
  logic [2:0] rate;
  logic [4:0] ov;
  int         fails, tests_run;
  ccr_regs #(.SHIP_SHORT_CYC(200), .SHIP_LONG_CYC(300), .POK_WAIT_CYC(50),
    .MS_CYC(20)) u_ccr_regs (
    .i_sys_clk(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_ack(ack), .i_sys_reset_done(done),
    .i_ship_long_sel(lsel), .i_ship_exit(sexit), .i_charge_fault(fault),
    .i_low_rail_ss_ok(ss_ok), .i_enable_pin(pin), .o_enable_pin_level(lvl), .o_enter_ship(ship),
    .o_power_ok_output(pok), .o_enable_pin_pulldown_on(pd), .o_converter_run(run),
    .o_gentle_drain_time(drain_t), .o_above_hearing_skip_on(skip), .o_high_rail_drain_on(hrd),
    .o_low_rail_drain_on(lrd), .o_constant_rate_on(crate), .o_low_rail_overcurrent_off(oc),
    .o_spread_spectrum_sel(spread), .o_channel_phase_sel(phase), .o_switching_rate_sel(rate),
    .o_high_rail_overvoltage_level(ov), .o_high_rail_exit_level(exit_lv));
  ccr_host_model u_ccr_host_model (.i_sys_clk(clk), .i_reg_rdata(rdata), .i_reg_ack(ack),
    .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd));
  // *****************************************************************
  // shared tasks
  // *****************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a read that never answers ends the run
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    u_ccr_host_model.rd(a, d, ok);
    `CHK("read ack", 1'b1, ok)
    if (!ok) summarize();
    `CHK("read data", e, d)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_defaults();
    rdc(8'h05, 8'h80);
    rdc(8'h06, 8'h16);
    rdc(8'h07, 8'h32);
    rdc(8'h08, 8'hb0);
  endtask
  // *****************************************************************
  // scenarios
  // *****************************************************************
  task automatic t_defaults();
    chk_defaults();
    rdc(8'h09, 8'h00);
    `CHK("drains", 2'h3, {hrd, lrd})
    `CHK("ov exit", 7'h58, {ov, exit_lv})
    // default code 0 needs 2500 high cycles whatever the millisecond scale
    pin = 1'b1;
    cyc(2499);
    `CHK("pin base early", 1'b0, lvl)
    cyc(2);
    `CHK("pin base time", 1'b1, lvl)
    pin = 1'b0;
    cyc(1);
    $display("defaults done");
  endtask
  task automatic t_fields();
    u_ccr_host_model.wr(8'h05, 8'hbf);
    rdc(8'h05, 8'hbf);
    u_ccr_host_model.wr(8'h05, 8'h00);
    `CHK("pull-down off", 1'b0, pd)
    u_ccr_host_model.wr(8'h06, 8'hff);
    `CHK("cfg a out", 6'h3f, {drain_t, skip, hrd, lrd, crate})
    u_ccr_host_model.wr(8'h07, 8'hff);
    `CHK("oc off", 1'b1, oc)
    rdc(8'h07, 8'hbf);
    u_ccr_host_model.wr(8'h08, 8'hff);
    rdc(8'h08, 8'hfb);
    `CHK("ov off code", 5'h1f, ov)
    for (int k = 0; k < 8; k++) begin
      u_ccr_host_model.wr(8'h07, {2'h0, k[1:0], k[0], k[2:0]});
      `CHK("rate", k[2:0], rate)
      `CHK("spread phase", {k[1:0], k[0]}, {spread, phase})
      u_ccr_host_model.wr(8'h08, {k[2:0], k[1:0], 1'b0, k[1:0]});
      `CHK("ov level", {k[2:0], k[1:0]}, ov)
      `CHK("exit level", k[1:0], exit_lv)
    end
    $display("fields done");
  endtask
  task automatic t_resets();
    u_ccr_host_model.wr(8'h07, 8'h00);
    u_ccr_host_model.wr(8'h05, 8'h7f);
    cyc(3);
    chk_defaults();
    u_ccr_host_model.wr(8'h07, 8'h00);
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(3);
    rdc(8'h07, 8'h00);
    u_ccr_host_model.wr(8'h05, 8'ha1);
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(3);
    chk_defaults();
    $display("resets done");
  endtask
  task automatic t_ship();
    int n;
    int lim;
    u_ccr_host_model.wr(8'h05, 8'h90);
    cyc(250);
    `CHK("one key", 1'b0, ship)
    u_ccr_host_model.wr(8'h05, 8'h80);
    for (int s = 0; s < 2; s++) begin
      lsel = s[0];
      lim = s ? 300 : 200;
      u_ccr_host_model.wr(8'h06, 8'h56);
      u_ccr_host_model.wr(8'h05, 8'h90);
      n = 0;
      while (ship !== 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
      end
      `CHK("ship delay", 1'b1, n >= lim - 3 && n <= lim + 3)
      if (n >= 400) summarize();
      sexit = 1'b1;
      cyc(1);
      sexit = 1'b0;
      rdc(8'h05, 8'h80);
      `CHK("ship off", 1'b0, ship)
    end
    u_ccr_host_model.wr(8'h06, 8'h16);
    $display("ship done");
  endtask
  task automatic t_run_pok_pin();
    u_ccr_host_model.wr(8'h05, 8'h83);
    `CHK("run on", 1'b1, run)
    fault = 1'b1;
    cyc(1);
    fault = 1'b0;
    `CHK("run cleared", 1'b0, run)
    ss_ok = 1'b1;
    cyc(45);
    `CHK("pok early", 1'b0, pok)
    cyc(10);
    `CHK("pok late", 1'b1, pok)
    ss_ok = 1'b0;
    u_ccr_host_model.wr(8'h06, 8'h96);
    ss_ok = 1'b1;
    cyc(1);
    `CHK("pok at once", 1'b1, pok)
    pin = 1'b1;
    cyc(10);
    pin = 1'b0;
    `CHK("short pulse", 1'b0, lvl)
    cyc(1);
    pin = 1'b1;
    cyc(30);
    `CHK("long pulse", 1'b1, lvl)
    pin = 1'b0;
    cyc(1);
    `CHK("pin dropped", 1'b0, lvl)
    $display("run pok pin done");
  endtask
  // *****************************************************************
  // clock, reset and sequence
  // *****************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {srst, done, lsel, sexit, fault, ss_ok, pin} = 7'h40;
    fails = 0;
    tests_run = 0;
    cyc(2);
    srst = 1'b0;
    t_defaults();
    t_fields();
    t_resets();
    t_ship();
    t_run_pok_pin();
    summarize();
  end
endmodule
bind ccr_regs ccr_regs_chk #(.MS_CYC(MS_CYC)) u_ccr_regs_chk (.i_sys_clk(i_sys_clk),
  .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_reg_ack(o_reg_ack), .i_sys_reset_done(i_sys_reset_done),
  .i_ship_exit(i_ship_exit), .i_charge_fault(i_charge_fault),
  .i_low_rail_ss_ok(i_low_rail_ss_ok), .i_enable_pin(i_enable_pin),
  .o_enable_pin_level(o_enable_pin_level), .o_enter_ship(o_enter_ship),
  .o_power_ok_output(o_power_ok_output), .o_enable_pin_pulldown_on(o_enable_pin_pulldown_on),
  .o_converter_run(o_converter_run), .o_low_rail_overcurrent_off(o_low_rail_overcurrent_off),
  .o_spread_spectrum_sel(o_spread_spectrum_sel), .o_channel_phase_sel(o_channel_phase_sel),
  .o_switching_rate_sel(o_switching_rate_sel));
`default_nettype wire
